// ==== hw/cef_pkg.sv ====
// shared constants, types and helpers of the channel a capture event block
package cef_pkg;
   localparam int CEF_ADR_W = 8;
   localparam logic [7:0] CEF_OFF_STATUS = 8'h00;
   localparam logic [7:0] CEF_OFF_MASK = 8'h04;
   localparam logic [7:0] CEF_OFF_CTRL = 8'h08;
   localparam logic [7:0] CEF_OFF_WINDOW = 8'h0C;
   localparam logic [7:0] CEF_OFF_THRESH = 8'h10;
   localparam logic [7:0] CEF_OFF_CAPSTAT = 8'h14;
   localparam int CEF_FLAG_SYNC = 3;
   localparam int CEF_FLAG_DONE = 2;
   localparam int CEF_FLAG_OVR = 1;
   localparam int CEF_DATA_W = 10;
   localparam int CEF_STOP_W = 12;
   localparam int CEF_CNT_W = 24;
   localparam int CEF_CTL_W = 10;
   localparam int CEF_CTL_CHRST = 14;
   localparam int CEF_CTL_PRST = 15;
   localparam int CEF_WIN_V_LO = 16;
   localparam int CEF_CAP_LVL_LO = 8;
   localparam int CEF_THRESH_RST = 8;
   localparam int CEF_FIFO_AW = 4;
   localparam logic [7:0] CEF_CODE_ONES = 8'hFF;
   localparam logic [7:0] CEF_CODE_ZERO = 8'h00;

   // control word, bit 9 down to bit 0
   typedef struct packed {
      logic ena;
      logic second_field_capture_bit;
      logic first_field_capture_bit;
      logic frame_capture_bit;
      logic repeat_capture_bit;
      logic raw_field_operation_enable;
      logic [2:0] cmode;
      logic transport_stream_mode;
   } cef_ctl_t;

   typedef struct packed {
      logic [CEF_STOP_W-1:0] window_vertical_stop;
      logic [CEF_STOP_W-1:0] window_horizontal_stop;
   } cef_stop_t;

   function automatic logic cef_is_sync_mode(input cef_ctl_t c);
      return !c.transport_stream_mode && !c.cmode[1];
   endfunction

   function automatic logic cef_is_raw_mode(input cef_ctl_t c);
      return !c.transport_stream_mode && c.cmode[1];
   endfunction

   // xy = data[9:2] of the fourth code word
   function automatic logic cef_xy_ok(input logic [7:0] xy);
      logic f, v, h;
      f = xy[6];
      v = xy[5];
      h = xy[4];
      return xy[7] && (xy[3] == (v ^ h)) && (xy[2] == (f ^ h)) && (xy[1] == (f ^ v)) && (xy[0] == (f ^ v ^ h));
   endfunction

   function automatic logic [31:0] cef_merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            r[i*8 +: 8] = wd[i*8 +: 8];
         end
      end
      return r;
   endfunction
endpackage

// ==== hw/cef_sync.sv ====
// two flip-flop synchroniser for pin inputs
`timescale 1ns/100ps
module cef_sync
   import cef_pkg::*;
#(parameter int W = 11)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } cef_sync_state_t;

   cef_sync_state_t st_r, st_nxt;

   // first stage feeds only the second
   always_comb begin
      st_nxt.s1 = rst ? '0 : d;
      st_nxt.s2 = rst ? '0 : st_r.s1;
   end

   always_ff @(posedge clk) begin
      st_r <= st_nxt;
   end

   assign q = st_r.s2;
endmodule

// ==== hw/cef_mem.sv ====
// capture fifo storage with registered read data
`timescale 1ns/100ps
module cef_mem
   import cef_pkg::*;
#(parameter int DW = CEF_DATA_W, parameter int AW = CEF_FIFO_AW)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic we,
   input wire logic [AW-1:0] waddr,
   input wire logic [DW-1:0] wdata,
   input wire logic [AW-1:0] raddr,
   output logic [DW-1:0] rdata
);
   typedef struct packed {
      logic [(1<<AW)-1:0][DW-1:0] mem;
      logic [DW-1:0] rd;
   } cef_mem_state_t;

   cef_mem_state_t st_r, st_nxt;

   // storage keeps its contents over reset, only the read register clears
   always_comb begin
      st_nxt = st_r;
      if (we) begin
         st_nxt.mem[waddr] = wdata;
      end
      st_nxt.rd = rst ? '0 : st_r.mem[raddr];
   end

   always_ff @(posedge clk) begin
      st_r <= st_nxt;
   end

   assign rdata = st_r.rd;
endmodule

// ==== hw/cef_top.sv ====
// channel a capture event flags with capture fifo and wishbone registers
`timescale 1ns/100ps
module cef_top
   import cef_pkg::*;
#(parameter int FIFO_AW = CEF_FIFO_AW)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [CEF_ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic [CEF_DATA_W-1:0] vid_data,
   input wire logic vid_capen,
   input wire logic dma_rd,
   output logic [CEF_DATA_W-1:0] dma_data,
   output logic dma_valid,
   output logic dma_req,
   output logic irq
);
   localparam int FL_W = FIFO_AW + 1;
   localparam logic [FL_W-1:0] DEPTH = FL_W'(1 << FIFO_AW);

   typedef struct packed {
      logic ack;
      logic [31:0] rdat;
      logic [3:1] stat;
      logic [3:1] mask;
      cef_ctl_t ctl;
      cef_stop_t stop;
      logic [FL_W-1:0] thresh;
      logic [7:0] h1;
      logic [7:0] h2;
      logic [7:0] h3;
      logic fld;
      logic vbl;
      logic hbl;
      logic [CEF_CNT_W-1:0] cnt;
      logic f1d;
      logic f2d;
      logic frd;
      logic f1seen;
      logic rawfld;
      logic stopped;
      logic [FIFO_AW-1:0] wp;
      logic [FIFO_AW-1:0] rp;
      logic [FL_W-1:0] level;
      logic dvalid;
      logic dreq;
      logic irq;
   } cef_state_t;

   localparam cef_state_t ST_RST = '{thresh: FL_W'(CEF_THRESH_RST), default: '0};

   cef_state_t st_r, st_nxt;
   logic [CEF_DATA_W:0] pin_q;
   logic [CEF_DATA_W-1:0] cap_d;
   logic cap_en;
   logic [7:0] samp;
   logic is_xy, is_rsv, xy_ok;
   logic mode_sync, mode_raw, mode_tsi, field_mode;
   logic armed, store, hit, cur_field;
   logic field_evt, f1_evt, f2_evt, frame_evt, complete_evt, sync_err_evt;
   logic pop, full, ovw;
   logic bus_req, bus_wr, bus_rd, hit_stat;
   logic [3:1] set_v, clr_v;

   cef_sync #(.W(CEF_DATA_W + 1)) u_sync (
      .clk(clk),
      .rst(rst),
      .d({vid_capen, vid_data}),
      .q(pin_q)
   );

   assign cap_d = pin_q[CEF_DATA_W-1:0];
   assign cap_en = pin_q[CEF_DATA_W];
   assign samp = cap_d[CEF_DATA_W-1 -: 8];

   assign mode_sync = cef_is_sync_mode(st_r.ctl);
   assign mode_raw = cef_is_raw_mode(st_r.ctl);
   assign mode_tsi = st_r.ctl.transport_stream_mode;
   assign field_mode = mode_sync || (mode_raw && st_r.ctl.raw_field_operation_enable);

   // word after ones/zero/zero preamble is the timing code
   assign is_xy = (st_r.h3 == CEF_CODE_ONES) && (st_r.h2 == CEF_CODE_ZERO) && (st_r.h1 == CEF_CODE_ZERO);
   assign is_rsv = (samp == CEF_CODE_ONES) || (samp == CEF_CODE_ZERO);
   assign xy_ok = cef_xy_ok(samp);
   assign sync_err_evt = st_r.ctl.ena && cap_en && mode_sync && is_xy && !xy_ok;

   assign armed = st_r.ctl.ena && !st_r.stopped && cap_en;
   // in sync mode reserved code words are not video, so they never enter the fifo; raw and stream modes store them
   assign store = armed && (mode_sync ? (!is_xy && !is_rsv && !st_r.vbl && !st_r.hbl) : 1'b1);
   assign hit = store && (st_r.cnt == st_r.stop);
   assign cur_field = mode_sync ? st_r.fld : (field_mode && st_r.rawfld);

   assign field_evt = hit && field_mode;
   assign f1_evt = field_evt && !cur_field;
   assign f2_evt = field_evt && cur_field;
   assign frame_evt = (hit && !field_mode) || (f2_evt && st_r.f1seen);
   // done is raised at the last stored word, not when dma has drained it
   assign complete_evt = (st_r.ctl.frame_capture_bit || !field_mode) ? frame_evt :
                         ((f1_evt && st_r.ctl.first_field_capture_bit) ||
                          (f2_evt && st_r.ctl.second_field_capture_bit));

   assign pop = dma_rd && st_r.dvalid;
   assign full = st_r.level == DEPTH;
   assign ovw = store && full && !pop;

   assign bus_req = wb_cyc_i && wb_stb_i;
   assign bus_wr = bus_req && st_r.ack && wb_we_i;
   assign bus_rd = bus_req && st_r.ack && !wb_we_i;
   assign hit_stat = wb_adr_i == CEF_OFF_STATUS;

   always_comb begin
      set_v = '0;
      set_v[CEF_FLAG_SYNC] = sync_err_evt;
      set_v[CEF_FLAG_DONE] = complete_evt;
      set_v[CEF_FLAG_OVR] = ovw;
      clr_v = '0;
      // write one clears; a read clears only what that read returned
      if (bus_wr && hit_stat && wb_sel_i[0]) begin
         clr_v = wb_dat_i[3:1];
      end
      if (bus_rd && hit_stat) begin
         clr_v = st_r.rdat[3:1];
      end
   end

   cef_mem #(.DW(CEF_DATA_W), .AW(FIFO_AW)) u_mem (
      .clk(clk),
      .rst(rst),
      .we(store),
      .waddr(st_r.wp),
      .wdata(cap_d),
      .raddr(st_r.rp),
      .rdata(dma_data)
   );

   always_comb begin
      logic [31:0] m;
      logic [31:0] rv;
      m = '0;
      rv = '0;
      st_nxt = st_r;

      // timing code decode and sample history
      if (cap_en) begin
         st_nxt.h1 = samp;
         st_nxt.h2 = st_r.h1;
         st_nxt.h3 = st_r.h2;
      end
      if (cap_en && mode_sync && is_xy && xy_ok) begin
         st_nxt.fld = samp[6];
         st_nxt.vbl = samp[5];
         st_nxt.hbl = samp[4];
         if (samp[6] != st_r.fld) begin
            st_nxt.cnt = '0;
         end else if (samp[4] && !st_r.hbl && !st_r.vbl && armed) begin
            st_nxt.cnt = {st_r.cnt[CEF_CNT_W-1 -: CEF_STOP_W] + CEF_STOP_W'(1), CEF_STOP_W'(0)};
         end
      end

      // data counter against the combined stop value
      if (hit) begin
         st_nxt.cnt = '0;
      end else if (store && mode_sync) begin
         st_nxt.cnt[CEF_STOP_W-1:0] = st_r.cnt[CEF_STOP_W-1:0] + CEF_STOP_W'(1);
      end else if (store) begin
         st_nxt.cnt = st_r.cnt + CEF_CNT_W'(1);
      end

      // done bits live until the first word of the next window
      st_nxt.f1d = f1_evt || (st_r.f1d && !(store && st_r.cnt == '0));
      st_nxt.f2d = f2_evt || (st_r.f2d && !(store && st_r.cnt == '0));
      st_nxt.frd = frame_evt || (st_r.frd && !(store && st_r.cnt == '0));
      if (f1_evt) begin
         st_nxt.f1seen = 1'b1;
      end else if (f2_evt) begin
         st_nxt.f1seen = 1'b0;
      end
      if (field_evt && !mode_sync) begin
         st_nxt.rawfld = !st_r.rawfld;
      end
      if (complete_evt && !st_r.ctl.repeat_capture_bit) begin
         st_nxt.stopped = 1'b1;
      end

      // fifo; when full the oldest word is dropped
      if (store) begin
         st_nxt.wp = st_r.wp + FIFO_AW'(1);
      end
      if (pop || ovw) begin
         st_nxt.rp = st_r.rp + FIFO_AW'(1);
      end
      if (store && !pop && !full) begin
         st_nxt.level = st_r.level + FL_W'(1);
      end else if (pop && !store) begin
         st_nxt.level = st_r.level - FL_W'(1);
      end
      // head word lags its pointer by one cycle, so valid skips that cycle
      st_nxt.dvalid = (st_r.level != '0) && !pop && !ovw;
      st_nxt.dreq = st_r.level >= st_r.thresh;

      st_nxt.stat = set_v | (st_r.stat & ~clr_v);

      // wishbone: ack one cycle after the request, effect at the ack edge
      st_nxt.ack = bus_req && !st_r.ack;
      st_nxt.rdat = '0;
      if (bus_req && !st_r.ack && !wb_we_i) begin
         case (wb_adr_i)
            CEF_OFF_STATUS: rv[3:1] = st_r.stat;
            CEF_OFF_MASK: rv[3:1] = st_r.mask;
            CEF_OFF_CTRL: rv[CEF_CTL_W-1:0] = st_r.ctl;
            CEF_OFF_WINDOW: begin
               rv[CEF_WIN_V_LO +: CEF_STOP_W] = st_r.stop.window_vertical_stop;
               rv[CEF_STOP_W-1:0] = st_r.stop.window_horizontal_stop;
            end
            CEF_OFF_THRESH: rv[FL_W-1:0] = st_r.thresh;
            CEF_OFF_CAPSTAT: begin
               rv[3:0] = {st_r.fld, st_r.frd, st_r.f2d, st_r.f1d};
               rv[CEF_CAP_LVL_LO +: FL_W] = st_r.level;
            end
            default: rv = '0;
         endcase
         st_nxt.rdat = rv;
      end

      if (bus_wr) begin
         case (wb_adr_i)
            CEF_OFF_MASK: begin
               m = cef_merge({28'h0, st_r.mask, 1'b0}, wb_dat_i, wb_sel_i);
               st_nxt.mask = m[3:1];
            end
            CEF_OFF_CTRL: begin
               m = cef_merge({22'h0, st_r.ctl}, wb_dat_i, wb_sel_i);
               st_nxt.ctl = m[CEF_CTL_W-1:0];
               st_nxt.stopped = 1'b0;
            end
            CEF_OFF_WINDOW: begin
               m = cef_merge({4'h0, st_r.stop.window_vertical_stop, 4'h0, st_r.stop.window_horizontal_stop},
                             wb_dat_i, wb_sel_i);
               st_nxt.stop.window_vertical_stop = m[CEF_WIN_V_LO +: CEF_STOP_W];
               st_nxt.stop.window_horizontal_stop = m[CEF_STOP_W-1:0];
            end
            CEF_OFF_THRESH: begin
               m = cef_merge(32'(st_r.thresh), wb_dat_i, wb_sel_i);
               st_nxt.thresh = m[FL_W-1:0];
            end
            default: m = '0;
         endcase
      end

      // recovery path after a sync error: channel reset keeps flags and setup
      if (bus_wr && wb_adr_i == CEF_OFF_CTRL && wb_sel_i[1] && wb_dat_i[CEF_CTL_CHRST]) begin
         st_nxt.h1 = '0;
         st_nxt.h2 = '0;
         st_nxt.h3 = '0;
         st_nxt.fld = 1'b0;
         st_nxt.vbl = 1'b0;
         st_nxt.hbl = 1'b0;
         st_nxt.cnt = '0;
         st_nxt.f1d = 1'b0;
         st_nxt.f2d = 1'b0;
         st_nxt.frd = 1'b0;
         st_nxt.f1seen = 1'b0;
         st_nxt.rawfld = 1'b0;
         st_nxt.wp = '0;
         st_nxt.rp = '0;
         st_nxt.level = '0;
         st_nxt.dvalid = 1'b0;
         st_nxt.dreq = 1'b0;
      end
      if (bus_wr && wb_adr_i == CEF_OFF_CTRL && wb_sel_i[1] && wb_dat_i[CEF_CTL_PRST]) begin
         st_nxt = ST_RST;
      end
      st_nxt.irq = |(st_nxt.stat & st_nxt.mask);
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st_r <= ST_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign wb_dat_o = st_r.rdat;
   assign wb_ack_o = st_r.ack;
   assign dma_valid = st_r.dvalid;
   assign dma_req = st_r.dreq;
   assign irq = st_r.irq;

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sync_err_set_a: assert property (sync_err_evt && !$past(rst) |=> st_r.stat[3] || $past(rst))
      else $error("sync error event did not set flag");
   sync_unused_a: assert property ($rose(st_r.stat[3]) |-> $past(cef_is_sync_mode(st_r.ctl)))
      else $error("sync flag set outside sync mode");
   done_set_a: assert property (complete_evt |=> st_r.stat[2] && (irq || !st_r.mask[2]))
      else $error("capture done did not set flag");
   raw_field_a: assert property (mode_raw && st_r.ctl.raw_field_operation_enable &&
                                 !st_r.ctl.frame_capture_bit &&
                                 ((f1_evt && st_r.ctl.first_field_capture_bit) ||
                                  (f2_evt && st_r.ctl.second_field_capture_bit)) |-> complete_evt)
      else $error("raw field done missed");
   raw_frame_a: assert property (complete_evt && mode_raw && !st_r.ctl.raw_field_operation_enable |-> hit)
      else $error("raw done without frame end");
   tsi_frame_a: assert property (complete_evt && mode_tsi |-> hit && st_r.cnt == st_r.stop)
      else $error("stream done without counter match");
   ovr_set_a: assert property (ovw |=> st_r.stat[1] && st_r.level == DEPTH)
      else $error("overwrite did not set overrun flag");
   w1c_clear_a: assert property (bus_wr && hit_stat && wb_sel_i[0] && wb_dat_i[2] && !complete_evt
                                 |=> !st_r.stat[2])
      else $error("write one did not clear done flag");
   reserved_zero_a: assert property (wb_ack_o && !wb_we_i && hit_stat |-> wb_dat_o[0] == 1'b0 &&
                                     wb_dat_o[31:4] == '0)
      else $error("reserved status bits not zero");
   dma_req_a: assert property (st_r.level >= st_r.thresh ##1 !$past(bus_wr) |-> dma_req)
      else $error("dma request missing at threshold");
   sticky_hold_a: assert property (st_r.stat[2] && clr_v[2] == 1'b0 && !$past(rst) ##1 !$past(bus_wr)
                                   |-> st_r.stat[2])
      else $error("done flag dropped without clear");
   irq_level_a: assert property (irq == |(st_r.stat & st_r.mask))
      else $error("interrupt not tied to masked status");

   done_seen_c: cover property (complete_evt ##1 irq);
   overrun_seen_c: cover property (ovw);
   sync_err_seen_c: cover property (sync_err_evt);
   dma_req_seen_c: cover property ($rose(dma_req) ##[1:20] pop);
endmodule

// ==== testbench/cef_vid_src.sv ====
// video source model driving the capture pins
`timescale 1ns/100ps
module cef_vid_src
   import cef_pkg::*;
(
   input wire logic clk,
   output logic [CEF_DATA_W-1:0] vid_data,
   output logic vid_capen
);
   initial begin
      vid_data = '0;
      vid_capen = 1'b0;
   end
   // one sample per call; back-to-back calls give a contiguous stream
   task automatic put(input logic [CEF_DATA_W-1:0] d);
      @(posedge clk);
      vid_capen <= 1'b1;
      vid_data <= d;
   endtask
   // released bus shows the inverse, so a stale word is never mistaken for data
   task automatic idle();
      @(posedge clk);
      vid_capen <= 1'b0;
      vid_data <= ~vid_data;
   endtask
   // preamble ff 00 00 then the code byte on bits 9:2
   task automatic code(input logic [7:0] xy);
      put({CEF_CODE_ONES, 2'b00});
      put({CEF_CODE_ZERO, 2'b00});
      put({CEF_CODE_ZERO, 2'b00});
      put({xy, 2'b00});
   endtask
endmodule

// ==== testbench/capture_chan_a_event_flags_test.sv ====
// self-checking bench for the channel a capture event flags
`timescale 1ns/100ps
module capture_chan_a_event_flags_test
   import cef_pkg::*;
;
   logic clk = 1'b0;
   logic rst;
   logic cyc, stb, we, dma_rd;
   logic [CEF_ADR_W-1:0] adr;
   logic [3:0] sel;
   logic [31:0] wdat, dat_o, rd;
   logic ack, dma_valid, dma_req, irq, capen;
   logic [CEF_DATA_W-1:0] vdata, dma_data;
   int failures = 0;
   int checks = 0;
   always #50 clk = ~clk;
   cef_vid_src i_src (.clk(clk), .vid_data(vdata), .vid_capen(capen));
   cef_top #(.FIFO_AW(4)) i_dut (.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
      .vid_data(vdata), .vid_capen(capen), .dma_rd(dma_rd), .dma_data(dma_data),
      .dma_valid(dma_valid), .dma_req(dma_req), .irq(irq));
   task automatic report_and_stop();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   // ack sampled at the rising edge; the write lands and read data is taken at that edge
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      sel <= s;
      do @(posedge clk); while (ack !== 1'b1);
      rd = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask
   task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
      wb(1'b0, a, '0, 4'hF);
      chk(what, exp, rd);
   endtask
   // channel reset with every new mode flushes fifo and counters
   task automatic setup(input logic [31:0] ctl, input logic [31:0] win);
      wb(1'b1, CEF_OFF_WINDOW, win, 4'hF);
      wb(1'b1, CEF_OFF_CTRL, 32'h0000_4000 | ctl, 4'h3);
   endtask
   task automatic t_reset_values();
      rchk("status", CEF_OFF_STATUS, 32'h0000_0000);
      rchk("mask", CEF_OFF_MASK, 32'h0000_0000);
      rchk("thresh", CEF_OFF_THRESH, CEF_THRESH_RST);
      wb(1'b1, 8'h20, 32'hFFFF_FFFF, 4'hF);
      rchk("unmapped", 8'h20, 32'h0000_0000);
   endtask
   // stop at 0: every stored sample ends a window; code words are plain data here
   task automatic t_raw_stream();
      logic [31:0] ctls [2];
      ctls = '{32'h0000_0224, 32'h0000_0225};
      foreach (ctls[i]) begin
         setup(ctls[i], 32'h0000_0000);
         i_src.code(8'h81);
         i_src.idle();
         wait_cyc(8);
         chk("irq unmasked", 32'h0, irq);
         chk("data waits in fifo", 32'h1, dma_valid);
         rchk("raw or stream flags", CEF_OFF_STATUS, 32'h0000_0004);
         rchk("read cleared", CEF_OFF_STATUS, 32'h0000_0000);
      end
   endtask
   // field 1 end must not complete when only field 2 is chosen
   task automatic t_raw_field();
      setup(32'h0000_0334, 32'h0000_0000);
      wb(1'b1, CEF_OFF_MASK, 32'h0000_000F, 4'hF);
      i_src.put(10'h155);
      i_src.idle();
      wait_cyc(8);
      chk("irq after field 1", 32'h0, irq);
      i_src.put(10'h2AA);
      i_src.idle();
      wait_cyc(8);
      chk("irq after field 2", 32'h1, irq);
      wb(1'b1, CEF_OFF_STATUS, 32'h0000_0005, 4'h1);
      wait_cyc(1);
      chk("irq after clear", 32'h0, irq);
      rchk("status after clear", CEF_OFF_STATUS, 32'h0000_0000);
      wb(1'b1, CEF_OFF_MASK, 32'h0000_0000, 4'hF);
   endtask
   task automatic t_sync();
      setup(32'h0000_0280, 32'h0000_0000);
      i_src.code(8'h80);
      i_src.put(10'h200);
      i_src.idle();
      wait_cyc(8);
      rchk("sync field done", CEF_OFF_STATUS, 32'h0000_0004);
      wb(1'b1, CEF_OFF_MASK, 32'h0000_0008, 4'hF);
      i_src.code(8'h81);
      i_src.idle();
      wait_cyc(8);
      chk("flag sticky", 32'h1, irq);
      wb(1'b1, CEF_OFF_STATUS, 32'h0000_0000, 4'h1);
      rchk("sync parity error", CEF_OFF_STATUS, 32'h0000_0008);
      setup(32'h0000_0280, 32'h0000_0000);
      rchk("after channel reset", CEF_OFF_STATUS, 32'h0000_0000);
   endtask
   // seventeen words into sixteen places with no pop drops the oldest
   task automatic t_overrun();
      setup(32'h0000_0224, 32'h0FFF_0FFF);
      for (int i = 0; i < 17; i++) begin
         i_src.put(10'h040 + i[9:0]);
      end
      i_src.idle();
      wait_cyc(6);
      chk("dma request", 32'h1, dma_req);
      rchk("overrun flag", CEF_OFF_STATUS, 32'h0000_0002);
      for (int i = 1; i < 3; i++) begin
         do @(negedge clk); while (dma_valid !== 1'b1);
         chk("fifo head", 32'h040 + i, dma_data);
         @(posedge clk);
         dma_rd <= 1'b1;
         @(posedge clk);
         dma_rd <= 1'b0;
      end
   endtask
   task automatic t_port_reset();
      wb(1'b1, CEF_OFF_THRESH, 32'h0000_0003, 4'hF);
      wb(1'b1, CEF_OFF_CTRL, 32'h0000_8000, 4'h2);
      rchk("thresh after port reset", CEF_OFF_THRESH, CEF_THRESH_RST);
      rchk("ctrl after port reset", CEF_OFF_CTRL, 32'h0000_0000);
   endtask
   initial begin
      rst <= 1'b1;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      dma_rd <= 1'b0;
      adr <= '0;
      sel <= '0;
      wdat <= '0;
      wait_cyc(12);
      rst <= 1'b0;
      wait_cyc(2);
      t_reset_values();
      t_raw_stream();
      t_raw_field();
      t_sync();
      t_overrun();
      t_port_reset();
      report_and_stop();
   end
   // the whole sequence takes well under a thousand cycles
   initial begin
      #(6000 * 100);
      failures++;
      report_and_stop();
   end
endmodule
